//--- shared/conv_ctrl_pkg.sv
// Package of constants and types for the converter control block
package conv_ctrl_pkg;

    localparam int          DATA_BITS       = 10;
    localparam int          DIV_BITS        = 5;
    localparam logic [4:0]  DIV_RESET       = 5'h1F;
    localparam int          TRACK_CLOCKS    = 3;
    localparam logic [3:0]  CONVERT_CLOCKS  = 4'hC;

    // Start-source encodings
    localparam logic [1:0]  SRC_SOFTWARE    = 2'h0;
    localparam logic [1:0]  SRC_TIMER3      = 2'h1;
    localparam logic [1:0]  SRC_STROBE      = 2'h2;
    localparam logic [1:0]  SRC_TIMER2      = 2'h3;

    // Channel code fields
    localparam int          CH_TEMP_BIT     = 3;
    localparam int          CH_POL_BIT      = 0;
    localparam logic [3:0]  CH_TEMP_OUT     = 4'h8;

    localparam logic [7:0]  RESULT_RESET    = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_TRACK   = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_LOAD    = 4'b1000
    } conv_state_e;

endpackage

//--- core/sar_tick_gen.sv
// Conversion clock tick generator dividing the system clock
`timescale 1ns/1ps
`default_nettype none
module sar_tick_gen
    import conv_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Control
    input  wire logic                run,
    input  wire logic [DIV_BITS-1:0] divisor,
    // Tick out
    output logic                     tick
);
    logic [DIV_BITS-1:0] count_r;
    logic [DIV_BITS-1:0] count_nxt;
    logic                tick_r;
    logic                tick_nxt;

    // One tick every divisor plus one system clocks
    always_comb begin
        count_nxt = count_r;
        tick_nxt  = 1'b0;
        if (!run) begin
            count_nxt = '0;
        end else if (count_r >= divisor) begin
            count_nxt = '0;
            tick_nxt  = 1'b1;
        end else begin
            count_nxt = count_r + 5'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= '0;
            tick_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule
`default_nettype wire

//--- core/result_formatter.sv
// Result formatting into high and low bytes
`timescale 1ns/1ps
`default_nettype none
module result_formatter
    import conv_ctrl_pkg::*;
(
    // Raw code and format controls
    input  wire logic [DATA_BITS-1:0] code,
    input  wire logic                 differential,
    input  wire logic                 left_justify_bit,
    // Formatted bytes
    output logic [7:0]                high_byte,
    output logic [7:0]                low_byte
);
    logic [15:0] word;

    always_comb begin
        word = 16'h0000;
        if (left_justify_bit) begin
            word = {code, 6'h00};
        end else if (differential) begin
            word = {{6{code[DATA_BITS-1]}}, code};
        end else begin
            word = {6'h00, code};
        end
        high_byte = word[15:8];
        low_byte  = word[7:0];
    end
endmodule
`default_nettype wire

//--- core/sar_adc_conversion_control.sv
// Conversion control for the auxiliary 10-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
// Function
// - Converts only while enable bit set
// - Selector routes single pin, pair, or sensor
// - Code 0000 even minus odd, 0001 reversed
// - Result bytes loaded, justified by control bit
// - Single-ended unsigned, unused bits zero
// - Differential two's complement, sign or zero fill
// - Conversion clock is system clock over divisor+1
// - Exactly one selected start source
// - Busy during conversion; fall sets done flag
// - Timer width picks low or high overflow
// - Normal mode tracks except while converting
// - Low-power mode tracks three clocks then converts
// - Low-power strobe mode tracks while strobe low
// - Tracking may stop in standby or sleep
// - Start field 00 sw, 01 t3, 10 strobe, 11 t2
// - Busy write 1 starts only in software mode
// - Pair bit set makes two inputs one pair
module sar_adc_conversion_control
    import conv_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Control bits
    input  wire logic                  converter_enable_bit,
    input  wire logic                  low_power_track_select,
    input  wire logic [1:0]            start_source_select,
    input  wire logic                  left_justify_bit,
    input  wire logic [DIV_BITS-1:0]   conversion_clock_divisor,
    input  wire logic [3:0]            pair_config_reg,
    input  wire logic [3:0]            channel_code,
    input  wire logic                  interrupt_enable,
    input  wire logic                  standby_mode,
    // Software strobes
    input  wire logic                  busy_write_one,
    input  wire logic                  done_flag_clear,
    // Start event sources
    input  wire logic                  timer3_low_overflow,
    input  wire logic                  timer3_high_overflow,
    input  wire logic                  timer3_16bit_mode,
    input  wire logic                  timer2_low_overflow,
    input  wire logic                  timer2_high_overflow,
    input  wire logic                  timer2_16bit_mode,
    input  wire logic                  external_convert_strobe,
    // Analog front end
    input  wire logic [DATA_BITS-1:0]  sar_code,
    output logic [3:0]                 mux_positive,
    output logic [3:0]                 mux_negative,
    output logic                       mux_differential,
    output logic                       track_enable,
    output logic                       sample_hold,
    output logic                       analog_power,
    // Status and results
    output logic                       conversion_in_progress_bit,
    output logic                       conversion_done_flag,
    output logic                       interrupt_request,
    output logic [7:0]                 result_high_byte,
    output logic [7:0]                 result_low_byte
);
    conv_state_e  state_r;
    conv_state_e  state_nxt;
    logic [3:0]   clk_count_r;
    logic [3:0]   clk_count_nxt;
    logic         strobe_prev_r;
    logic         busy_r;
    logic         busy_nxt;
    logic         done_r;
    logic         done_nxt;
    logic         irq_r;
    logic         irq_nxt;
    logic [7:0]   high_r;
    logic [7:0]   high_nxt;
    logic [7:0]   low_r;
    logic [7:0]   low_nxt;
    logic [3:0]   pos_r;
    logic [3:0]   pos_nxt;
    logic [3:0]   neg_r;
    logic [3:0]   neg_nxt;
    logic         diff_r;
    logic         diff_nxt;
    logic         track_r;
    logic         track_nxt;
    logic         hold_r;
    logic         hold_nxt;
    logic         power_r;
    logic         power_nxt;
    logic         start_event;
    logic         strobe_rise;
    logic         tick;
    logic         conv_diff_r;
    logic         conv_diff_nxt;
    logic [7:0]   fmt_high;
    logic [7:0]   fmt_low;

    // Pick the overflow matching the timer width
    function automatic logic timer_overflow(input logic low_ovf, input logic high_ovf,
                                            input logic wide);
        timer_overflow = wide ? high_ovf : low_ovf;
    endfunction

    // Pair configuration bit covering a channel code
    function automatic logic pair_is_diff(input logic [3:0] code, input logic [3:0] cfg);
        pair_is_diff = !code[CH_TEMP_BIT] && cfg[code[2:1]];
    endfunction

    sar_tick_gen u_tick (
        .clock   (clock),
        .rst     (rst),
        .run     (converter_enable_bit),
        .divisor (conversion_clock_divisor),
        .tick    (tick)
    );

    result_formatter u_fmt (
        .code             (sar_code),
        .differential     (conv_diff_r),
        .left_justify_bit (left_justify_bit),
        .high_byte        (fmt_high),
        .low_byte         (fmt_low)
    );

    assign strobe_rise = external_convert_strobe && !strobe_prev_r;

    // Exactly one source is honoured
    always_comb begin
        case (start_source_select)
            SRC_SOFTWARE: start_event = busy_write_one;
            SRC_TIMER3:   start_event = timer_overflow(timer3_low_overflow,
                                            timer3_high_overflow, timer3_16bit_mode);
            SRC_STROBE:   start_event = strobe_rise;
            SRC_TIMER2:   start_event = timer_overflow(timer2_low_overflow,
                                            timer2_high_overflow, timer2_16bit_mode);
            default:      start_event = 1'b0;
        endcase
    end

    // Sequencer
    always_comb begin
        state_nxt     = state_r;
        clk_count_nxt = clk_count_r;
        busy_nxt      = busy_r;
        conv_diff_nxt = conv_diff_r;
        high_nxt      = high_r;
        low_nxt       = low_r;
        done_nxt      = done_r;
        irq_nxt       = irq_r;
        case (state_r)
            ST_IDLE: begin
                if (converter_enable_bit && start_event) begin
                    busy_nxt      = 1'b1;
                    clk_count_nxt = 4'h0;
                    conv_diff_nxt = pair_is_diff(channel_code, pair_config_reg);
                    if (low_power_track_select && start_source_select != SRC_STROBE) begin
                        state_nxt = ST_TRACK;
                    end else begin
                        state_nxt = ST_CONVERT;
                    end
                end
            end
            ST_TRACK: begin
                if (tick) begin
                    clk_count_nxt = clk_count_r + 4'h1;
                    if (clk_count_r == 4'(TRACK_CLOCKS - 1)) begin
                        clk_count_nxt = 4'h0;
                        state_nxt     = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    clk_count_nxt = clk_count_r + 4'h1;
                    if (clk_count_r == CONVERT_CLOCKS - 4'h1) begin
                        state_nxt = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                high_nxt  = fmt_high;
                low_nxt   = fmt_low;
                busy_nxt  = 1'b0;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
                busy_nxt  = 1'b0;
            end
        endcase
        if (!converter_enable_bit) begin
            state_nxt = ST_IDLE;
            busy_nxt  = 1'b0;
        end
        // Set wins over clear; flag sticks
        if (state_r == ST_LOAD) begin
            done_nxt = 1'b1;
        end else if (done_flag_clear) begin
            done_nxt = 1'b0;
        end
        irq_nxt = done_nxt && interrupt_enable;
    end

    // Input selector
    always_comb begin
        diff_nxt = pair_is_diff(channel_code, pair_config_reg);
        pos_nxt  = channel_code[CH_TEMP_BIT] ? CH_TEMP_OUT : channel_code;
        neg_nxt  = 4'h0;
        if (diff_nxt) begin
            pos_nxt = channel_code;
            neg_nxt = {channel_code[3:1], ~channel_code[CH_POL_BIT]};
        end
    end

    // Track-and-hold and power control
    always_comb begin
        power_nxt = converter_enable_bit;
        hold_nxt  = (state_nxt == ST_CONVERT) || (state_nxt == ST_LOAD);
        track_nxt = 1'b0;
        if (converter_enable_bit && !standby_mode) begin
            if (!low_power_track_select) begin
                track_nxt = !hold_nxt;
            end else if (start_source_select == SRC_STROBE) begin
                track_nxt = !external_convert_strobe && !hold_nxt;
            end else begin
                track_nxt = (state_nxt == ST_TRACK);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r       <= ST_IDLE;
            clk_count_r   <= 4'h0;
            strobe_prev_r <= 1'b1;                                       // Pin idles high
            busy_r        <= 1'b0;
            done_r        <= 1'b0;
            irq_r         <= 1'b0;
            high_r        <= RESULT_RESET;
            low_r         <= RESULT_RESET;
            conv_diff_r   <= 1'b0;
            pos_r         <= 4'h0;
            neg_r         <= 4'h0;
            diff_r        <= 1'b0;
            track_r       <= 1'b0;
            hold_r        <= 1'b0;
            power_r       <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            clk_count_r   <= clk_count_nxt;
            strobe_prev_r <= external_convert_strobe;
            busy_r        <= busy_nxt;
            done_r        <= done_nxt;
            irq_r         <= irq_nxt;
            high_r        <= high_nxt;
            low_r         <= low_nxt;
            conv_diff_r   <= conv_diff_nxt;
            pos_r         <= pos_nxt;
            neg_r         <= neg_nxt;
            diff_r        <= diff_nxt;
            track_r       <= track_nxt;
            hold_r        <= hold_nxt;
            power_r       <= power_nxt;
        end
    end

    assign conversion_in_progress_bit = busy_r;
    assign conversion_done_flag       = done_r;
    assign interrupt_request          = irq_r;
    assign result_high_byte           = high_r;
    assign result_low_byte            = low_r;
    assign mux_positive               = pos_r;
    assign mux_negative               = neg_r;
    assign mux_differential           = diff_r;
    assign track_enable               = track_r;
    assign sample_hold                = hold_r;
    assign analog_power               = power_r;
endmodule
`default_nettype wire

//--- verification/conv_ctrl_props.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_props
    import conv_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic                                clock,
    input wire logic                                rst,
    // Controls and strobes
    input wire logic                                converter_enable_bit,
    input wire logic                                low_power_track_select,
    input wire logic [1:0]                          start_source_select,
    input wire logic [conv_ctrl_pkg::DIV_BITS-1:0]  conversion_clock_divisor,
    input wire logic                                interrupt_enable,
    input wire logic                                standby_mode,
    input wire logic                                busy_write_one,
    input wire logic                                done_flag_clear,
    input wire logic                                timer3_low_overflow,
    input wire logic                                timer3_high_overflow,
    // Outputs watched
    input wire logic                                track_enable,
    input wire logic                                conversion_in_progress_bit,
    input wire logic                                conversion_done_flag,
    input wire logic                                interrupt_request,
    input wire logic [7:0]                          result_high_byte,
    input wire logic [7:0]                          result_low_byte
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [9:0] len_r;
    logic [9:0] len_nxt;
    logic [9:0] d1;
    logic [9:0] ticks;
    // Busy length counter and expected tick count
    always_comb begin
        len_nxt = conversion_in_progress_bit ? len_r + 10'h001 : 10'h000;
        d1 = 10'(conversion_clock_divisor) + 10'h001;
        ticks = (low_power_track_select && start_source_select != SRC_STROBE) ? 10'h00F : 10'h00C;
    end
    always_ff @(posedge clock) begin
        len_r <= rst ? 10'h000 : len_nxt;
    end
    sequence s_finish;
        !$past(rst) && $fell(conversion_in_progress_bit) && $past(converter_enable_bit);
    endsequence
    sequence s_idle_normal;
        converter_enable_bit && !low_power_track_select && !standby_mode
            && !conversion_in_progress_bit;
    endsequence
    property p_off_idle;
        !converter_enable_bit |=> !conversion_in_progress_bit;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("busy while disabled");
    property p_sw_start;
        busy_write_one && start_source_select == SRC_SOFTWARE && converter_enable_bit
            && !conversion_in_progress_bit && !low_power_track_select |=> conversion_in_progress_bit;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start lost");
    property p_sw_only;
        busy_write_one && start_source_select == SRC_TIMER3 && !timer3_low_overflow
            && !timer3_high_overflow && !conversion_in_progress_bit |=> !conversion_in_progress_bit;
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("busy write started timer mode");
    property p_done_set;
        s_finish |-> conversion_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set at busy fall");
    property p_done_sticky;
        conversion_done_flag && !done_flag_clear |=> conversion_done_flag;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped");
    property p_irq;
        1'b1 |=> interrupt_request == (conversion_done_flag && $past(interrupt_enable));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request mismatch");
    property p_results_hold;
        !$past(rst) && !$fell(conversion_in_progress_bit)
            |-> $stable(result_high_byte) && $stable(result_low_byte);
    endproperty
    a_results_hold: assert property (p_results_hold) else $error("result changed mid-run");
    property p_conv_len;
        s_finish |-> len_r >= (ticks - 10'h001) * d1 + 10'h001 && len_r <= ticks * d1 + 10'h003;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_track_idle;
        s_idle_normal [*3] |-> track_enable;
    endproperty
    a_track_idle: assert property (p_track_idle) else $error("no tracking while idle");
endmodule
`default_nettype wire

//--- verification/timer_strobe_model.sv
// Timer overflow and external strobe source model
`timescale 1ns/1ps
`default_nettype none
module timer_strobe_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Bench request
    input  wire logic       fire,
    input  wire logic [1:0] kind,
    input  wire logic       wide,
    input  wire logic [3:0] delay,
    // Start events
    output logic            timer3_low_overflow,
    output logic            timer3_high_overflow,
    output logic            timer2_low_overflow,
    output logic            timer2_high_overflow,
    output logic            external_convert_strobe
);
    logic [3:0] cnt_r;
    logic       armed_r;
    logic       go;
    logic       lo;
    logic       hi;
    // Other byte overflows on request, selected byte after the delay
    assign go = armed_r && cnt_r == 4'h0;
    assign lo = (fire && wide) || (go && !wide);
    assign hi = (fire && !wide) || (go && wide);
    always_ff @(posedge clock) begin
        timer3_low_overflow <= kind == 2'h1 && lo;
        timer3_high_overflow <= kind == 2'h1 && hi;
        timer2_low_overflow <= kind == 2'h3 && lo;
        timer2_high_overflow <= kind == 2'h3 && hi;
        if (rst || go) begin
            armed_r <= 1'b0;
            external_convert_strobe <= 1'b1;
        end else if (fire) begin
            armed_r <= 1'b1;
            cnt_r <= delay;
            external_convert_strobe <= kind != 2'h2;
        end else begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- verification/sar_adc_conversion_control_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_tb;
    import conv_ctrl_pkg::*;
    typedef struct packed {
        logic [15:0] res;
        logic [8:0]  mux;
    } exp_s;
    logic       clock = 1'b0, rst = 1'b1, converter_enable_bit = 1'b0;
    logic       low_power_track_select = 1'b0, left_justify_bit = 1'b0, interrupt_enable = 1'b0;
    logic       standby_mode = 1'b0, busy_write_one = 1'b0, done_flag_clear = 1'b0;
    logic       fire = 1'b0, wide = 1'b0, busy_q = 1'b0;
    logic [1:0] start_source_select = 2'h0;
    logic [4:0] conversion_clock_divisor = 5'h03;
    logic [3:0] pair_config_reg = 4'h0, channel_code = 4'h0, delay = 4'h3;
    logic [9:0] sar_code = 10'h000;
    logic       timer3_low_overflow, timer3_high_overflow, timer2_low_overflow;
    logic       timer2_high_overflow, external_convert_strobe, mux_differential;
    logic       track_enable, sample_hold, analog_power, conversion_in_progress_bit;
    logic       conversion_done_flag, interrupt_request;
    logic [3:0] mux_positive, mux_negative;
    logic [7:0] result_high_byte, result_low_byte;
    logic [9:0] tbl [4] = '{10'h3FF, 10'h200, 10'h1FF, 10'h000};
    int         err_count = 0, n_compared = 0, cycles = 0;
    exp_s       exp_q[$];
    exp_s       got;
    logic [3:0] ctl_view;
    logic       track_want;
    assign ctl_view   = {analog_power, conversion_in_progress_bit, sample_hold, track_enable};
    assign track_want = !standby_mode && !low_power_track_select;
    sar_adc_conversion_control DUT (
        .clock, .rst, .converter_enable_bit, .low_power_track_select, .start_source_select,
        .left_justify_bit, .conversion_clock_divisor, .pair_config_reg, .channel_code,
        .interrupt_enable, .standby_mode, .busy_write_one, .done_flag_clear,
        .timer3_low_overflow, .timer3_high_overflow, .timer3_16bit_mode(wide),
        .timer2_low_overflow, .timer2_high_overflow, .timer2_16bit_mode(wide),
        .external_convert_strobe, .sar_code, .mux_positive, .mux_negative, .mux_differential,
        .track_enable, .sample_hold, .analog_power, .conversion_in_progress_bit,
        .conversion_done_flag, .interrupt_request, .result_high_byte, .result_low_byte
    );
    timer_strobe_model partner (
        .clock, .rst, .fire, .kind(start_source_select), .wide, .delay,
        .timer3_low_overflow, .timer3_high_overflow, .timer2_low_overflow,
        .timer2_high_overflow, .external_convert_strobe
    );
    always #50 clock = ~clock;
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic sw_pulse();
        busy_write_one <= 1'b1;
        @(posedge clock);
        busy_write_one <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic run_one(input int i);
        logic [9:0] code;
        logic       diff;
        int         k;
        code = (i < 4) ? tbl[i] : 10'($urandom);
        start_source_select <= 2'(i);
        low_power_track_select <= i[2];
        left_justify_bit <= 1'($urandom);
        pair_config_reg <= 4'($urandom);
        channel_code <= 4'($urandom);
        conversion_clock_divisor <= (i == 23) ? 5'h1F : 5'($urandom_range(5, 3));
        interrupt_enable <= 1'($urandom);
        standby_mode <= 1'($urandom);
        wide <= 1'($urandom);
        delay <= 4'($urandom_range(15, 3));
        sar_code <= code;
        @(posedge clock);
        diff = !channel_code[3] && pair_config_reg[channel_code[2:1]];
        exp_q.push_back({left_justify_bit ? {code, 6'h00} : {{6{diff && code[9]}}, code},
            channel_code[3] ? 4'h8 : channel_code, diff ? channel_code ^ 4'h1 : 4'h0, diff});
        if (i[1:0] == 2'h0) begin
            busy_write_one <= 1'b1;
            @(posedge clock);
            busy_write_one <= 1'b0;
        end else begin
            fire <= 1'b1;
            @(posedge clock);
            fire <= 1'b0;
            repeat (2) @(posedge clock);
            @(negedge clock);
            if (i[1:0] != 2'h2 || !i[2]) begin
                check("early", {15'h0000, conversion_in_progress_bit}, 16'h0000);
            end else begin
                check("track", {15'h0000, track_enable}, {15'h0000, !standby_mode});
            end
        end
        k = 0;
        while (conversion_done_flag !== 1'b1 && k < 1000) begin
            @(posedge clock);
            k++;
        end
        check("done", {15'h0000, conversion_done_flag}, 16'h0001);
        @(posedge clock);
        done_flag_clear <= 1'b1;
        @(posedge clock);
        done_flag_clear <= 1'b0;
    endtask
    always @(negedge clock) begin
        if (busy_q && conversion_in_progress_bit === 1'b0 && converter_enable_bit) begin
            got = exp_q.pop_front();
            check("result", {result_high_byte, result_low_byte}, got.res);
            check("mux", {7'h00, mux_positive, mux_negative, mux_differential}, {7'h00, got.mux});
            check("flag", {15'h0000, conversion_done_flag}, 16'h0001);
            check("idle", {12'h000, ctl_view}, {15'h0004, track_want});
        end
        busy_q = conversion_in_progress_bit === 1'b1;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        void'($urandom(83));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        sw_pulse();
        check("off", {12'h000, ctl_view}, 16'h0000);
        @(posedge clock);
        converter_enable_bit <= 1'b1;
        start_source_select <= SRC_TIMER3;
        repeat (4) @(posedge clock);
        sw_pulse();
        check("refused", {15'h0000, conversion_in_progress_bit}, 16'h0000);
        @(posedge clock);
        start_source_select <= SRC_SOFTWARE;
        sw_pulse();
        check("start", {12'h000, ctl_view}, 16'h000E);
        @(posedge clock);
        converter_enable_bit <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("abort", {12'h000, ctl_view}, 16'h0000);
        @(posedge clock);
        converter_enable_bit <= 1'b1;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 24; i++) begin
            run_one(i);
        end
        test_done();
    end
endmodule
bind sar_adc_conversion_control conv_ctrl_props u_props (
    .clock, .rst, .converter_enable_bit, .low_power_track_select, .start_source_select,
    .conversion_clock_divisor, .interrupt_enable, .standby_mode, .busy_write_one,
    .done_flag_clear, .timer3_low_overflow, .timer3_high_overflow, .track_enable,
    .conversion_in_progress_bit, .conversion_done_flag, .interrupt_request,
    .result_high_byte, .result_low_byte
);
`default_nettype wire
